// *** src/xmove_pkg.sv ***
// constants, types and register map for the external data access block
package xmove_pkg;

  // ****************************************
  // register indices (byte address is index * 4)
  // ****************************************
  localparam logic [9:0] IDX_CLOCK_CONTROL = 10'h080;
  localparam logic [9:0] IDX_POINTER_A     = 10'h081;
  localparam logic [9:0] IDX_POINTER_B     = 10'h082;
  localparam logic [9:0] IDX_PORT2_LATCH   = 10'h083;
  localparam logic [9:0] IDX_INDIRECT_REG  = 10'h084;
  localparam logic [9:0] IDX_ACCUMULATOR   = 10'h085;
  localparam logic [9:0] IDX_POINTER_SEL   = 10'h086;
  localparam logic [9:0] IDX_COMMAND       = 10'h087;
  localparam logic [9:0] IDX_POINTER_INC   = 10'h088;

  // ****************************************
  // reset values and fields
  // ****************************************
  localparam logic [7:0] CLOCK_CONTROL_RST = 8'h01;
  localparam logic [7:0] POINTER_SEL_RST   = 8'h00;
  localparam int         STRETCH_LSB       = 0;
  localparam int         STRETCH_W         = 3;
  localparam int         CMD_GO_BIT        = 0;
  localparam int         CMD_WRITE_BIT     = 1;
  localparam int         CMD_INDIRECT_BIT  = 2;
  localparam int         CMD_PLAIN_BIT     = 3;

  // ****************************************
  // timing
  // ****************************************
  localparam logic [5:0] CYCLE_CLKS        = 6'h04;
  localparam logic [5:0] SHORT_STROBE      = 6'h02;
  localparam logic [5:0] SHORT_STROBE_BEG  = 6'h01;
  localparam logic [5:0] LONG_STROBE_BEG   = 6'h02;

  // ****************************************
  // axi answers
  // ****************************************
  localparam logic [1:0] RESP_OKAY         = 2'h0;
  localparam logic [1:0] RESP_DECERR       = 2'h3;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_FETCH  = 4'h2,
    ST_ACCESS = 4'h4,
    ST_DONE   = 4'h8
  } seq_state_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        rd_n;
    logic        wr_n;
  } ext_bus_t;

endpackage : xmove_pkg

// *** src/xmove_top.sv ***
// external move sequencer with data pointers, access stretch and axi4-lite registers
// What this block does
// R1: indirect move: low address from indirect_reg, high from port 2 latch.
// R2: pointer move: full 16-bit address from selected data pointer.
// R3: two 16-bit pointers, chosen by bit 0 of pointer_select at 86h.
// R4: pointer_select bits 7..1 do nothing and read as zero.
// R5: select 0 uses pointer_a, select 1 uses pointer_b.
// R6: incrementing pointer_select toggles the active pointer.
// R7: every external move starts with a four-clock opcode fetch cycle.
// R8: the next machine cycle drives the address and performs the access.
// R9: stretch comes from bits 2..0 of clock_control, eight settings.
// R10: stretch 0..7 gives external moves of 2..9 machine cycles.
// R11: processor state is held frozen during the stretched cycles.
// R12: only external moves are stretched; other instructions keep timing.
// R13: stretch resets to 1; 0 gives the fastest two-cycle move.
// R14: strobe lasts 2 clocks at stretch 0, else four per stretch unit.
// R15: a machine cycle is four successive clock states.
// R16: external memory completes its part within the selected strobe width.
// R17: read data is captured into the accumulator as the read strobe ends.
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module xmove_top
(
  // clock and reset
  input  wire logic              CLK_IN,
  input  wire logic              SRST_IN,
  // axi4-lite write address and data
  input  wire logic [11:0]       S_AXI_AWADDR_IN,
  input  wire logic              S_AXI_AWVALID_IN,
  output logic                   S_AXI_AWREADY_OUT,
  input  wire logic [31:0]       S_AXI_WDATA_IN,
  input  wire logic [3:0]        S_AXI_WSTRB_IN,
  input  wire logic              S_AXI_WVALID_IN,
  output logic                   S_AXI_WREADY_OUT,
  // axi4-lite write response
  output logic [1:0]             S_AXI_BRESP_OUT,
  output logic                   S_AXI_BVALID_OUT,
  input  wire logic              S_AXI_BREADY_IN,
  // axi4-lite read
  input  wire logic [11:0]       S_AXI_ARADDR_IN,
  input  wire logic              S_AXI_ARVALID_IN,
  output logic                   S_AXI_ARREADY_OUT,
  output logic [31:0]            S_AXI_RDATA_OUT,
  output logic [1:0]             S_AXI_RRESP_OUT,
  output logic                   S_AXI_RVALID_OUT,
  input  wire logic              S_AXI_RREADY_IN,
  // external data bus
  output xmove_pkg::ext_bus_t    XBUS_OUT,
  output logic                   XDATA_OE_N_OUT,
  input  wire logic [7:0]        XDATA_IN,
  // core status
  output logic                   CPU_HOLD_OUT,
  output logic                   BUSY_OUT
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [5:0] strobe_len(input logic [2:0] s);
    strobe_len = (s == 3'h0) ? xmove_pkg::SHORT_STROBE : 6'({s, 2'b00}); // R14
  endfunction : strobe_len

  function automatic logic [5:0] strobe_beg(input logic [2:0] s);
    strobe_beg = (s == 3'h0) ? xmove_pkg::SHORT_STROBE_BEG : xmove_pkg::LONG_STROBE_BEG;
  endfunction : strobe_beg

  function automatic logic [5:0] access_len(input logic [2:0] s);
    // one machine cycle plus one per stretch unit
    access_len = 6'({s, 2'b00}) + xmove_pkg::CYCLE_CLKS; // R10
  endfunction : access_len

  // ****************************************
  // registers
  // ****************************************
  logic [7:0]             clock_control_q;
  logic                   pointer_select_q;
  logic [15:0]            pointer_a_q;
  logic [15:0]            pointer_b_q;
  logic [7:0]             port2_q;
  logic [7:0]             indirect_q;
  logic [7:0]             acc_q;
  logic                   cmd_write_q;
  logic                   cmd_indirect_q;
  logic                   cmd_plain_q;
  xmove_pkg::seq_state_t  state_q;
  xmove_pkg::seq_state_t  state_d;
  logic [5:0]             cnt_q;
  logic [5:0]             cnt_d;
  logic [2:0]             stretch_q;
  logic                   strobe_q;
  logic                   strobe_d;
  xmove_pkg::ext_bus_t    bus_q;
  logic                   oe_n_q;

  // axi side
  logic                   bvalid_q;
  logic [1:0]             bresp_q;
  logic                   rvalid_q;
  logic [1:0]             rresp_q;
  logic [31:0]            rdata_q;
  logic                   wr_fire;
  logic                   rd_fire;
  logic [9:0]             wr_idx;
  logic [9:0]             rd_idx;
  logic                   wr_lo;
  logic                   wr_hi;
  logic                   start;

  // ****************************************
  // axi4-lite slave
  // ****************************************
  // address and data are taken together; both must be offered
  assign S_AXI_AWREADY_OUT = S_AXI_AWVALID_IN & S_AXI_WVALID_IN & ~bvalid_q;
  assign S_AXI_WREADY_OUT  = S_AXI_AWREADY_OUT;
  assign S_AXI_ARREADY_OUT = ~rvalid_q;
  assign wr_fire           = S_AXI_AWREADY_OUT;
  assign rd_fire           = S_AXI_ARVALID_IN & S_AXI_ARREADY_OUT;
  assign wr_idx            = S_AXI_AWADDR_IN[11:2];
  assign rd_idx            = S_AXI_ARADDR_IN[11:2];
  assign wr_lo             = wr_fire & S_AXI_WSTRB_IN[0];
  assign wr_hi             = wr_fire & S_AXI_WSTRB_IN[1];
  assign S_AXI_BVALID_OUT  = bvalid_q;
  assign S_AXI_BRESP_OUT   = bresp_q;
  assign S_AXI_RVALID_OUT  = rvalid_q;
  assign S_AXI_RRESP_OUT   = rresp_q;
  assign S_AXI_RDATA_OUT   = rdata_q;

  function automatic logic mapped(input logic [9:0] idx);
    mapped = (idx >= xmove_pkg::IDX_CLOCK_CONTROL) && (idx <= xmove_pkg::IDX_POINTER_INC);
  endfunction : mapped

  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= xmove_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_q <= 1'b1;
      bresp_q  <= mapped(wr_idx) ? xmove_pkg::RESP_OKAY : xmove_pkg::RESP_DECERR;
    end
    else if (S_AXI_BREADY_IN)
    begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
    begin
      rvalid_q <= 1'b0;
      rresp_q  <= xmove_pkg::RESP_OKAY;
      rdata_q  <= 32'h0;
    end
    else if (rd_fire)
    begin
      rvalid_q <= 1'b1;
      rresp_q  <= mapped(rd_idx) ? xmove_pkg::RESP_OKAY : xmove_pkg::RESP_DECERR;
      case (rd_idx)
        xmove_pkg::IDX_CLOCK_CONTROL: rdata_q <= {24'h0, clock_control_q};
        xmove_pkg::IDX_POINTER_A:     rdata_q <= {16'h0, pointer_a_q};
        xmove_pkg::IDX_POINTER_B:     rdata_q <= {16'h0, pointer_b_q};
        xmove_pkg::IDX_PORT2_LATCH:   rdata_q <= {24'h0, port2_q};
        xmove_pkg::IDX_INDIRECT_REG:  rdata_q <= {24'h0, indirect_q};
        xmove_pkg::IDX_ACCUMULATOR:   rdata_q <= {24'h0, acc_q};
        xmove_pkg::IDX_POINTER_SEL:   rdata_q <= {31'h0, pointer_select_q}; // R4
        xmove_pkg::IDX_COMMAND:       rdata_q <= {24'h0, state_q, cmd_plain_q, cmd_indirect_q,
                                                  cmd_write_q, BUSY_OUT};
        default:                      rdata_q <= 32'h0;
      endcase
    end
    else if (S_AXI_RREADY_IN)
    begin
      rvalid_q <= 1'b0;
    end
  end

  // ****************************************
  // software registers
  // ****************************************
  // a command written while busy is dropped; the status word shows why
  assign start = wr_lo & (wr_idx == xmove_pkg::IDX_COMMAND)
                 & S_AXI_WDATA_IN[xmove_pkg::CMD_GO_BIT] & (state_q == xmove_pkg::ST_IDLE);

  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
      clock_control_q <= xmove_pkg::CLOCK_CONTROL_RST; // R13
    else if (wr_lo && wr_idx == xmove_pkg::IDX_CLOCK_CONTROL)
      clock_control_q <= S_AXI_WDATA_IN[7:0];
  end

  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
      pointer_select_q <= xmove_pkg::POINTER_SEL_RST[0];
    else if (wr_lo && wr_idx == xmove_pkg::IDX_POINTER_SEL)
      pointer_select_q <= S_AXI_WDATA_IN[0]; // R3
    else if (wr_fire && wr_idx == xmove_pkg::IDX_POINTER_INC)
      pointer_select_q <= ~pointer_select_q; // R6
  end

  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
    begin
      pointer_a_q <= 16'h0;
      pointer_b_q <= 16'h0;
    end
    else if (wr_idx == xmove_pkg::IDX_POINTER_A)
    begin
      if (wr_lo)
        pointer_a_q[7:0]  <= S_AXI_WDATA_IN[7:0];
      if (wr_hi)
        pointer_a_q[15:8] <= S_AXI_WDATA_IN[15:8];
    end
    else if (wr_idx == xmove_pkg::IDX_POINTER_B)
    begin
      if (wr_lo)
        pointer_b_q[7:0]  <= S_AXI_WDATA_IN[7:0];
      if (wr_hi)
        pointer_b_q[15:8] <= S_AXI_WDATA_IN[15:8];
    end
  end

  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
    begin
      port2_q    <= 8'h0;
      indirect_q <= 8'h0;
    end
    else if (wr_lo && wr_idx == xmove_pkg::IDX_PORT2_LATCH)
      port2_q    <= S_AXI_WDATA_IN[7:0];
    else if (wr_lo && wr_idx == xmove_pkg::IDX_INDIRECT_REG)
      indirect_q <= S_AXI_WDATA_IN[7:0];
  end

  // the strobe end wins over a software write landing in the same cycle
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
      acc_q <= 8'h0;
    else if (strobe_q && !strobe_d && !cmd_write_q)
      acc_q <= XDATA_IN; // R17
    else if (wr_lo && wr_idx == xmove_pkg::IDX_ACCUMULATOR && state_q == xmove_pkg::ST_IDLE)
      acc_q <= S_AXI_WDATA_IN[7:0]; // R11
  end

  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
    begin
      cmd_write_q    <= 1'b0;
      cmd_indirect_q <= 1'b0;
      cmd_plain_q    <= 1'b0;
      stretch_q      <= 3'h0;
    end
    else if (start)
    begin
      cmd_write_q    <= S_AXI_WDATA_IN[xmove_pkg::CMD_WRITE_BIT];
      cmd_indirect_q <= S_AXI_WDATA_IN[xmove_pkg::CMD_INDIRECT_BIT];
      cmd_plain_q    <= S_AXI_WDATA_IN[xmove_pkg::CMD_PLAIN_BIT];
      // stretch is latched per instruction so a mid-access write cannot tear it
      stretch_q      <= clock_control_q[xmove_pkg::STRETCH_LSB +: xmove_pkg::STRETCH_W]; // R9
    end
  end

  // ****************************************
  // machine cycle sequencer
  // ****************************************
  always_comb
  begin
    state_d  = state_q;
    cnt_d    = cnt_q + 6'h01;
    strobe_d = 1'b0;
    case (state_q)
      xmove_pkg::ST_IDLE:
      begin
        cnt_d = 6'h0;
        if (start)
          state_d = xmove_pkg::ST_FETCH;
      end
      xmove_pkg::ST_FETCH:
      begin
        // four states per machine cycle
        if (cnt_q == xmove_pkg::CYCLE_CLKS - 6'h01) // R15
        begin
          cnt_d   = 6'h0;
          // plain instructions end after their fetch, unstretched
          state_d = cmd_plain_q ? xmove_pkg::ST_DONE : xmove_pkg::ST_ACCESS; // R7 R12
        end
      end
      xmove_pkg::ST_ACCESS:
      begin
        if (cnt_q == access_len(stretch_q) - 6'h01) // R10
        begin
          cnt_d   = 6'h0;
          state_d = xmove_pkg::ST_DONE;
        end
      end
      xmove_pkg::ST_DONE:
      begin
        cnt_d   = 6'h0;
        state_d = xmove_pkg::ST_IDLE;
      end
      default:
      begin
        cnt_d   = 6'h0;
        state_d = xmove_pkg::ST_IDLE;
      end
    endcase
    if (state_d == xmove_pkg::ST_ACCESS && cnt_d >= strobe_beg(stretch_q)
        && cnt_d < strobe_beg(stretch_q) + strobe_len(stretch_q))
      strobe_d = 1'b1; // R14
  end

  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
    begin
      state_q  <= xmove_pkg::ST_IDLE;
      cnt_q    <= 6'h0;
      strobe_q <= 1'b0;
    end
    else
    begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      strobe_q <= strobe_d;
    end
  end

  // ****************************************
  // external bus
  // ****************************************
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
    begin
      bus_q  <= '{addr: 16'h0, wdata: 8'h0, rd_n: 1'b1, wr_n: 1'b1};
      oe_n_q <= 1'b1;
    end
    else
    begin
      if (state_q == xmove_pkg::ST_FETCH && state_d == xmove_pkg::ST_ACCESS) // R8
      begin
        if (cmd_indirect_q)
          bus_q.addr <= {port2_q, indirect_q}; // R1
        else
          bus_q.addr <= pointer_select_q ? pointer_b_q : pointer_a_q; // R2 R5
        bus_q.wdata <= acc_q;
      end
      bus_q.rd_n <= ~(strobe_d & ~cmd_write_q);
      bus_q.wr_n <= ~(strobe_d & cmd_write_q);
      // data lines are driven across the whole write access cycle
      oe_n_q     <= ~(state_d == xmove_pkg::ST_ACCESS && cmd_write_q);
    end
  end

  assign XBUS_OUT       = bus_q;
  assign XDATA_OE_N_OUT = oe_n_q;
  assign BUSY_OUT       = (state_q != xmove_pkg::ST_IDLE);
  // beyond the first access cycle the core is frozen waiting for slow memory
  assign CPU_HOLD_OUT   = (state_q == xmove_pkg::ST_ACCESS) && (cnt_q >= xmove_pkg::CYCLE_CLKS); // R11 R16

endmodule : xmove_top

`default_nettype wire

// *** tb/xmem_model.sv ***
// behavioural external data memory on the far side of the move block
`timescale 1ns/100ps
`default_nettype none

module xmem_model
(
  // clock
  input  wire logic                 clk_in,
  // bus from the device
  input  wire xmove_pkg::ext_bus_t  bus_in,
  input  wire logic                 oe_n_in,
  output logic [7:0]                data_out
);
  // ****
  // storage
  // ****
  logic [7:0] mem [0:255];
  logic [7:0] last_q;

  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'ha5;
    last_q = 8'h00;
  end

  // no pull on the data lines: a released bus shows the inverse, never a stale byte
  assign data_out = !bus_in.rd_n ? mem[bus_in.addr[7:0]] : ~last_q;

  always @(posedge clk_in)
  begin
    if (!bus_in.rd_n)
      last_q <= mem[bus_in.addr[7:0]];
    if (!bus_in.wr_n && !oe_n_in)
      mem[bus_in.addr[7:0]] <= bus_in.wdata;
  end
endmodule : xmem_model

`default_nettype wire

// *** tb/xmove_properties.sv ***
// port checker for the external move block
`timescale 1ns/100ps
`default_nettype none

module xmove_properties
(
  // clock and reset
  input wire logic                CLK_IN,
  input wire logic                SRST_IN,
  // external side and core status
  input wire xmove_pkg::ext_bus_t XBUS_OUT,
  input wire logic                XDATA_OE_N_OUT,
  input wire logic                CPU_HOLD_OUT,
  input wire logic                BUSY_OUT
);
  // ****
  // helpers
  // ****
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (SRST_IN);

  logic       strb;
  logic [5:0] scnt_q;
  logic [5:0] bcnt_q;

  assign strb = !XBUS_OUT.rd_n || !XBUS_OUT.wr_n;

  // run lengths count the clocks before the present one
  always_ff @(posedge CLK_IN)
    scnt_q <= (SRST_IN || !strb) ? 6'h00 : scnt_q + 6'h01;
  always_ff @(posedge CLK_IN)
    bcnt_q <= (SRST_IN || !BUSY_OUT) ? 6'h00 : bcnt_q + 6'h01;

  // ****
  // properties
  // ****
  fetch_quiet_a: assert property ($rose(BUSY_OUT) |-> (!strb && $stable(XBUS_OUT.addr)) [*4])
    else $error("bus moved during fetch");
  early_hold_a: assert property ($rose(BUSY_OUT) |-> !CPU_HOLD_OUT [*8])
    else $error("hold too early");
  hold_busy_a: assert property (CPU_HOLD_OUT |-> BUSY_OUT)
    else $error("hold outside a move");
  hold_start_a: assert property ($rose(CPU_HOLD_OUT) |-> strb)
    else $error("hold began off strobe");
  strobe_width_a: assert property (strb |-> scnt_q < 6'h1c)
    else $error("strobe too long");
  move_len_a: assert property (BUSY_OUT |-> bcnt_q < 6'h25)
    else $error("move too long");
  strobe_excl_a: assert property (!(!XBUS_OUT.rd_n && !XBUS_OUT.wr_n))
    else $error("both strobes low");
  addr_steady_a: assert property (strb |-> $stable(XBUS_OUT.addr))
    else $error("address moved under strobe");
  write_drive_a: assert property (!XBUS_OUT.wr_n |-> !XDATA_OE_N_OUT && $stable(XBUS_OUT.wdata))
    else $error("write data not driven");
endmodule : xmove_properties

bind xmove_top xmove_properties i_xmove_properties
(
  .CLK_IN         (CLK_IN),
  .SRST_IN        (SRST_IN),
  .XBUS_OUT       (XBUS_OUT),
  .XDATA_OE_N_OUT (XDATA_OE_N_OUT),
  .CPU_HOLD_OUT   (CPU_HOLD_OUT),
  .BUSY_OUT       (BUSY_OUT)
);

`default_nettype wire

// *** tb/xmove_top_test.sv ***
// self-checking bench for the external move block
`timescale 1ns/100ps
`default_nettype none

module xmove_top_test;
  // ****
  // signals
  // ****
  logic                clk, srst, awvalid, wvalid, bready, arvalid, rready;
  logic                awready, wready, bvalid, arready, rvalid, oe_n, hold, busy;
  logic [11:0]         awaddr, araddr;
  logic [31:0]         wdata, rdata;
  logic [1:0]          bresp, rresp;
  logic [7:0]          xdata;
  logic [15:0]         saddr;
  xmove_pkg::ext_bus_t xbus;
  int                  errors = 0, checks_done = 0, bcnt = 0, scnt = 0, hcnt = 0, b0, s0, h0, d7;

  xmove_top i_xmove_top
  (
    .CLK_IN(clk), .SRST_IN(srst),
    .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
    .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(4'hf), .S_AXI_WVALID_IN(wvalid), .S_AXI_WREADY_OUT(wready),
    .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
    .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready),
    .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready),
    .XBUS_OUT(xbus), .XDATA_OE_N_OUT(oe_n), .XDATA_IN(xdata), .CPU_HOLD_OUT(hold), .BUSY_OUT(busy)
  );

  xmem_model i_xmem_model (.clk_in(clk), .bus_in(xbus), .oe_n_in(oe_n), .data_out(xdata));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // clocks of busy, strobe and hold, and the address under the strobe
  always @(posedge clk)
  begin
    bcnt <= bcnt + int'(busy);
    scnt <= scnt + int'(!xbus.rd_n || !xbus.wr_n);
    hcnt <= hcnt + int'(hold);
    if (!xbus.rd_n || !xbus.wr_n)
      saddr <= xbus.addr;
  end

  // ****
  // tasks
  // ****
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [9:0] i, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr <= {i, 2'b00};
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    do @(posedge clk); while (!(awready && wready));
    {awvalid, wvalid} <= 2'h0;
    while (!bvalid) @(posedge clk);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask : wr

  task automatic rd(input logic [9:0] i, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clk);
    araddr <= {i, 2'b00};
    {arvalid, rready} <= 2'h3;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge clk);
    rready <= 1'b0;
    chk(rdata, exp);
    chk({30'h0, rresp}, {30'h0, er});
  endtask : rd

  task automatic mv(input logic [3:0] cmd);
    b0 = bcnt;
    s0 = scnt;
    h0 = hcnt;
    wr(xmove_pkg::IDX_COMMAND, {28'h0, cmd}, 2'h0);
    repeat (8) if (!busy) @(posedge clk);
    repeat (60) if (busy) @(posedge clk);
    chk({31'h0, busy}, 32'h0);
  endtask : mv

  task automatic end_sim;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim

  // ****
  // tests
  // ****
  initial
  begin
    srst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 56'h0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd(xmove_pkg::IDX_CLOCK_CONTROL, 32'h01, 2'h0);
    rd(xmove_pkg::IDX_POINTER_SEL, 32'h00, 2'h0);
    wr(xmove_pkg::IDX_POINTER_SEL, 32'hff, 2'h0);
    rd(xmove_pkg::IDX_POINTER_SEL, 32'h01, 2'h0);
    wr(xmove_pkg::IDX_POINTER_INC, 32'h00, 2'h0);
    rd(xmove_pkg::IDX_POINTER_SEL, 32'h00, 2'h0);
    wr(xmove_pkg::IDX_POINTER_INC, 32'h00, 2'h0);
    rd(xmove_pkg::IDX_POINTER_SEL, 32'h01, 2'h0);
    wr(10'h0ff, 32'h55, 2'h3);
    rd(10'h0ff, 32'h00, 2'h3);
    wr(xmove_pkg::IDX_POINTER_A, 32'hc413, 2'h0);
    wr(xmove_pkg::IDX_POINTER_B, 32'h2b7e, 2'h0);
    for (int s = 0; s < 8; s++)
    begin
      wr(xmove_pkg::IDX_CLOCK_CONTROL, 32'(s), 2'h0);
      wr(xmove_pkg::IDX_POINTER_SEL, 32'(s % 2), 2'h0);
      mv(4'h1);
      chk(32'(bcnt - b0), 32'(4 * s + 9));
      chk(32'(scnt - s0), (s == 0) ? 32'h2 : 32'(4 * s));
      chk(32'(hcnt - h0), 32'(4 * s));
      chk({16'h0, saddr}, (s % 2) ? 32'h2b7e : 32'hc413);
      rd(xmove_pkg::IDX_ACCUMULATOR, (s % 2) ? 32'hdb : 32'hb6, 2'h0);
    end
    wr(xmove_pkg::IDX_PORT2_LATCH, 32'h5a, 2'h0);
    wr(xmove_pkg::IDX_INDIRECT_REG, 32'h3c, 2'h0);
    wr(xmove_pkg::IDX_ACCUMULATOR, 32'h77, 2'h0);
    mv(4'h7);
    chk({16'h0, saddr}, 32'h5a3c);
    wr(xmove_pkg::IDX_ACCUMULATOR, 32'h00, 2'h0);
    mv(4'h5);
    rd(xmove_pkg::IDX_ACCUMULATOR, 32'h77, 2'h0);
    // pointer write through pointer_b, read back through the same pointer
    mv(4'h3);
    chk({16'h0, saddr}, 32'h2b7e);
    wr(xmove_pkg::IDX_ACCUMULATOR, 32'h00, 2'h0);
    mv(4'h1);
    rd(xmove_pkg::IDX_ACCUMULATOR, 32'h77, 2'h0);
    mv(4'h9);
    chk(32'(scnt - s0), 32'h0);
    chk(32'(hcnt - h0), 32'h0);
    d7 = bcnt - b0;
    // a plain instruction is one fetch cycle plus the closing clock
    chk(32'(d7), 32'h5);
    wr(xmove_pkg::IDX_CLOCK_CONTROL, 32'h00, 2'h0);
    mv(4'h9);
    chk(32'(bcnt - b0), 32'(d7));
    chk({16'h0, xbus.addr}, 32'h2b7e);
    end_sim();
  end

  // the tests need a few hundred clocks
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    end_sim();
  end
endmodule : xmove_top_test

`default_nettype wire
